// ===== rtl/rsc_ctrl.v
/*
 Reset and stop-recovery controller: sequences system resets and stop
 recovery, records the cause, drives the shared reset pin open-drain and
 guards the pin function select with a two-write unlock.
 Assumes analog detectors, watchdog and oscillator come in as levels or
 pulses; pin-level inputs are synchronised here.
*/
// The implementer's own choices: the register offsets and the strobed register port.
`include "rsc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl (
  input wire clk,
  input wire rst,
  input wire por_hold,
  input wire brownout_detect,
  input wire brownout_stop_keep,
  input wire watchdog_timeout,
  input wire watchdog_reset_select,
  input wire fault_detect,
  input wire stop_mode,
  input wire osc_tick_pin,
  input wire reset_pin_in,
  input wire [7:0] recovery_pins,
  input wire [7:0] recovery_enable,
  input wire option_fault_select_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output wire reset_pin_out,
  output wire reset_pin_oe,
  output wire pwm_fault_input_zero,
  output reg chip_reset,
  output reg debugger_reset_n,
  output reg sys_clk_enable,
  output reg osc_ctrl_reset,
  output reg [15:0] vector_addr,
  output reg vector_fetch,
  output reg watchdog_exception
);
  localparam ST_RUN = 5'b00001;
  localparam ST_OSC = 5'b00010;
  localparam ST_SYS = 5'b00100;
  localparam ST_PIN = 5'b01000;
  localparam ST_SMR = 5'b10000;
  reg [4:0] state_reg;
  reg [6:0] osc_cnt_reg;
  reg [4:0] sys_cnt_reg;
  reg [2:0] filt_cnt_reg;
  reg [4:0] cause_reg;
  reg [4:0] pend_reg;
  reg sel_reg;
  reg [1:0] lock_reg;
  reg dbg_req_reg;
  reg drive_low_reg;
  reg wdt_exc_pend_reg;
  reg full_reset_reg;
  reg init_done_reg;
  // Two-stage synchronisers for every pin-level input
  reg [1:0] osc_s;
  reg [1:0] pin_s;
  reg [7:0] gp_s1;
  reg [7:0] gp_s2;
  reg [7:0] gp_last;
  reg osc_last;
  wire osc_edge;
  wire pin_low;
  wire ext_filtered;
  wire ext_event;
  wire bo_active;
  wire power_event;
  wire wdt_reset;
  wire [7:0] gp_edge;
  wire smr_event;
  wire internal_src;
  wire run_next;
  always @(posedge clk) begin
    if (rst) begin
      osc_s <= 2'b00;
      pin_s <= 2'b11;
      gp_s1 <= 8'h00;
      gp_s2 <= 8'h00;
      gp_last <= 8'h00;
      osc_last <= 1'b0;
    end else begin
      osc_s <= {osc_s[0], osc_tick_pin};
      pin_s <= {pin_s[0], reset_pin_in};
      gp_s1 <= recovery_pins;
      gp_s2 <= gp_s1;
      gp_last <= gp_s2;
      osc_last <= osc_s[1];
    end
  end
  assign osc_edge = osc_s[1] & ~osc_last;
  // The pin only acts as reset input when selected so; own drive is not a request
  assign pin_low = ~pin_s[1] & ~sel_reg & ~drive_low_reg; // R20 R25
  assign ext_filtered = pin_low & (filt_cnt_reg == `RSC_FILT_LEN - 3'd1); // R7
  assign ext_event = stop_mode ? pin_low : ext_filtered; // R10
  assign bo_active = brownout_detect & (~stop_mode | brownout_stop_keep); // R5
  assign power_event = por_hold | bo_active; // R4
  assign wdt_reset = watchdog_timeout & watchdog_reset_select & ~stop_mode; // R6
  // Recovery pins are sampled at 200 MHz, so pulses under one period may be lost
  assign gp_edge = (gp_s2 ^ gp_last) & recovery_enable; // R19
  assign smr_event = stop_mode & (|gp_edge | watchdog_timeout); // R18 R19
  assign internal_src = wdt_reset | dbg_req_reg | fault_detect;
  // Core hold follows the next state so the pin indicator never leads it
  assign run_next = ~power_event & (
    ((state_reg == ST_RUN) & ~(ext_event | internal_src | smr_event)) |
    ((state_reg == ST_SYS) & (sys_cnt_reg == `RSC_SYS_POST - 5'd1)) |
    ((state_reg == ST_SMR) & osc_edge & (osc_cnt_reg == `RSC_OSC_RESET - 7'd1)));
  always @(posedge clk) begin
    if (rst | ~pin_low) begin
      filt_cnt_reg <= 3'd0;
    end else if (filt_cnt_reg != `RSC_FILT_LEN - 3'd1) begin
      filt_cnt_reg <= filt_cnt_reg + 3'd1; // R7
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_OSC;
      osc_cnt_reg <= 7'd0;
      sys_cnt_reg <= 5'd0;
      pend_reg <= 5'b10000;
      cause_reg <= 5'd0;
      drive_low_reg <= 1'b1;
      full_reset_reg <= 1'b1;
      dbg_req_reg <= 1'b0;
      lock_reg <= 2'd0;
      wdt_exc_pend_reg <= 1'b0;
      vector_fetch <= 1'b0;
      vector_addr <= 16'h0000;
      watchdog_exception <= 1'b0;
      osc_ctrl_reset <= 1'b0;
    end else begin
      vector_fetch <= 1'b0;
      watchdog_exception <= 1'b0;
      osc_ctrl_reset <= 1'b0;
      if (wr && addr == `RSC_ADDR_CAUSE) begin
        case (lock_reg)
          2'd0: lock_reg <= (wdata == `RSC_UNLOCK1) ? 2'd1 : 2'd0; // R21 R26
          2'd1: lock_reg <= (wdata == `RSC_UNLOCK2) ? 2'd2 : 2'd0; // R21 R26
          default: lock_reg <= 2'd0;
        endcase
      end
      if (power_event) begin
        // Power events restart the full sequence from any state
        state_reg <= ST_OSC; // R23
        osc_cnt_reg <= 7'd0;
        pend_reg <= 5'b10000; // R4
        full_reset_reg <= 1'b1;
        drive_low_reg <= 1'b1;
      end else begin
        case (state_reg)
          ST_RUN: begin
            if (ext_event | internal_src) begin
              state_reg <= ST_OSC;
              osc_cnt_reg <= 7'd0;
              full_reset_reg <= 1'b0;
              // Pull the pin at once, so a short external pulse still stretches
              drive_low_reg <= 1'b1; // R9 R12
              pend_reg <= {dbg_req_reg, 1'b0, wdt_reset, ext_event, fault_detect}; // R6 R11 R13 R14
            end else if (smr_event) begin
              state_reg <= ST_SMR;
              osc_cnt_reg <= 7'd0;
              pend_reg <= {1'b0, 1'b1, watchdog_timeout, 1'b0, 1'b0}; // R18 R19
              wdt_exc_pend_reg <= watchdog_timeout & ~watchdog_reset_select; // R18
            end
          end
          ST_OSC: begin
            dbg_req_reg <= 1'b0; // R13
            if (ext_event) begin
              pend_reg[`RSC_BIT_EXT - 3] <= 1'b1;
            end
            if (osc_edge) begin
              osc_cnt_reg <= osc_cnt_reg + 7'd1;
            end
            if (osc_edge && osc_cnt_reg == `RSC_OSC_RESET - 7'd1) begin
              state_reg <= ST_PIN; // R22
              drive_low_reg <= 1'b0;
              sys_cnt_reg <= 5'd0;
            end else if (osc_edge && osc_cnt_reg == `RSC_OSC_PRE - 7'd1) begin
              drive_low_reg <= drive_low_reg | ~pin_low; // R9
            end
          end
          ST_PIN: begin
            // Pin still held low past the timeout: wait for release, then count
            if (~pin_s[1] & ~sel_reg) begin
              sys_cnt_reg <= 5'd0; // R8
            end else begin
              state_reg <= ST_SYS;
            end
          end
          ST_SYS: begin
            sys_cnt_reg <= sys_cnt_reg + 5'd1;
            if (sys_cnt_reg == `RSC_SYS_POST - 5'd1) begin
              state_reg <= ST_RUN; // R2 R8
              cause_reg <= pend_reg; // R24
              vector_fetch <= 1'b1; // R3
              vector_addr <= `RSC_VEC_ADDR;
              full_reset_reg <= 1'b0;
            end
          end
          ST_SMR: begin
            if (osc_edge) begin
              osc_cnt_reg <= osc_cnt_reg + 7'd1;
            end
            if (osc_edge && osc_cnt_reg == `RSC_OSC_RESET - 7'd1) begin
              state_reg <= ST_RUN; // R15
              cause_reg <= pend_reg; // R17 R24
              osc_ctrl_reset <= 1'b1; // R16
              vector_fetch <= 1'b1; // R17
              vector_addr <= `RSC_VEC_ADDR;
              watchdog_exception <= wdt_exc_pend_reg; // R18
              wdt_exc_pend_reg <= 1'b0;
            end
          end
          default: state_reg <= ST_OSC;
        endcase
      end
      // A new request in the clearing cycle wins over the self-clear
      if (wr && addr == `RSC_ADDR_DBG && wdata[`RSC_BIT_DBGRST]) begin
        dbg_req_reg <= 1'b1; // R13
      end
    end
  end
  // Select loads from the option bit only on a full reset, else by unlocked write
  always @(posedge clk) begin
    if (rst) begin
      sel_reg <= 1'b0;
      init_done_reg <= 1'b0;
    end else if (full_reset_reg & ~init_done_reg) begin
      sel_reg <= ~option_fault_select_n;
      init_done_reg <= 1'b1;
    end else if (wr && addr == `RSC_ADDR_CAUSE && lock_reg == 2'd2) begin
      sel_reg <= wdata[`RSC_BIT_SEL]; // R20 R21
    end
    if (~rst & ~full_reset_reg) begin
      init_done_reg <= 1'b0;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      chip_reset <= 1'b1;
      debugger_reset_n <= 1'b0;
      sys_clk_enable <= 1'b0;
    end else begin
      // Stop recovery keeps peripheral state: only the processor core is held
      chip_reset <= ~run_next; // R1 R2 R15
      debugger_reset_n <= ~full_reset_reg; // R13
      sys_clk_enable <= ~((state_reg == ST_OSC) & (osc_cnt_reg < `RSC_OSC_PRE)); // R1
    end
  end
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = drive_low_reg & ~sel_reg; // R12 R9
  assign pwm_fault_input_zero = ~pin_s[1] & sel_reg; // R25
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `RSC_ADDR_CAUSE: rdata <= {cause_reg, 2'b00, sel_reg}; // R24
        `RSC_ADDR_DBG: rdata <= {7'd0, dbg_req_reg};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/rsc_map.vh
/*
 Constants for the reset and stop-recovery controller: register offsets,
 status bit positions, unlock codes and timing counts.
 Assumes a single 200 MHz clk; the internal oscillator arrives as a pin level.
*/
// How it works
// R1 - After supply is stable count 50 oscillator cycles, then enable system clock.
// R2 - Then count 16 system clocks; whole chip held in reset until done.
// R3 - Leaving power-on reset, processor fetches reset vector; power-on flag reads 1.
// R4 - Brownout forces and holds reset, then full sequence, setting power-on flag.
// R5 - Brownout active in stop mode only when brownout_stop_keep is set.
// R6 - Watchdog timeout resets in normal/halt if reset select is 1; sets watchdog flag.
// R7 - External reset low at least 4 system clocks passes the filter.
// R8 - Reset held while pin low; exit 16 clocks after release if beyond timeout.
// R9 - Pin released early is driven low by device until timeout ends.
// R10 - In stop mode the external reset filter is bypassed.
// R11 - External pin reset sets external_reset_flag.
// R12 - Internal reset sources pull the pin low open-drain until delay elapses.
// R13 - Debugger request resets all but debugger, self-clears, sets power-on flag.
// R14 - Fault detect forces system reset and sets fault_reset_flag.
// R15 - Stop recovery holds chip in reset 66 oscillator cycles.
// R16 - Stop recovery changes only cause register and oscillator control.
// R17 - After stop recovery, vector fetched from 0002h/0003h; stop flag reads 1.
// R18 - Watchdog timeout in stop mode recovers, setting watchdog and stop flags.
// R19 - Any edge on an enabled recovery pin starts stop recovery, sets stop flag.
// R20 - Fault-input selection disables pin reset; software write overrides option bit.
// R21 - Unlock by writing 14h then 92h before writing pin_function_select.
// R22 - Every system reset lasts at least 66 oscillator cycles, pin held low.
// R23 - Power-on or brownout takes priority over every other reset source.
// R24 - Cause flags at bits 7..3, select at bit 0, updated every reset.
// R25 - Select 0 means reset input, 1 means pwm_fault_input_zero.
// R26 - Out-of-order write leaves select unchanged and relocks.
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
`define RSC_ADDR_CAUSE 4'h0
`define RSC_ADDR_DBG 4'h1
`define RSC_BIT_POR 7
`define RSC_BIT_STOP 6
`define RSC_BIT_WDT 5
`define RSC_BIT_EXT 4
`define RSC_BIT_FLT 3
`define RSC_BIT_SEL 0
`define RSC_BIT_DBGRST 0
`define RSC_UNLOCK1 8'h14
`define RSC_UNLOCK2 8'h92
`define RSC_OSC_PRE 7'd50
`define RSC_OSC_RESET 7'd66
`define RSC_SYS_POST 5'd16
`define RSC_FILT_LEN 3'd4
`define RSC_VEC_ADDR 16'h0002
`endif

// ===== verification/rsc_ctrl_properties.sv
/* Concurrent checks on the reset and stop-recovery controller ports.
   Assumes a single clk domain with synchronous active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl_properties (
  input wire clk,
  input wire rst,
  input wire brownout_detect,
  input wire watchdog_timeout,
  input wire watchdog_reset_select,
  input wire stop_mode,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire reset_pin_out,
  input wire reset_pin_oe,
  input wire chip_reset,
  input wire debugger_reset_n,
  input wire [15:0] vector_addr,
  input wire vector_fetch,
  input wire osc_ctrl_reset,
  input wire sys_clk_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_dbg_req;
    wr && addr == 4'h1 && wdata[0] && !chip_reset;
  endsequence
  sequence s_exit;
    $fell(chip_reset);
  endsequence
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata not zero outside read");
  a_pin_low_only: assert property (reset_pin_out == 1'b0)
    else $error("reset pin driven high");
  a_oe_in_reset: assert property (reset_pin_oe |-> chip_reset)
    else $error("pin pulled outside reset");
  a_exit_fetch: assert property (s_exit |-> ##[0:2] vector_fetch)
    else $error("no vector fetch at reset exit");
  a_vector_addr: assert property (vector_fetch |-> vector_addr == 16'h0002)
    else $error("wrong vector address");
  a_brownout_holds: assert property (brownout_detect && !stop_mode [*3] |-> chip_reset)
    else $error("brownout not holding reset");
  a_dbg_keeps: assert property (s_dbg_req |=> debugger_reset_n [*8])
    else $error("debugger reset by its own request");
  a_dbg_starts: assert property (s_dbg_req |-> ##[1:4] chip_reset)
    else $error("debug request ignored");
  a_wdt_reset: assert property (watchdog_timeout && watchdog_reset_select && !stop_mode
    && !chip_reset |-> ##[1:4] chip_reset)
    else $error("watchdog timeout ignored");
  a_osc_ctrl_exit: assert property (osc_ctrl_reset |-> vector_fetch)
    else $error("oscillator control reset outside recovery exit");
  a_clk_off_held: assert property (!sys_clk_enable |-> chip_reset)
    else $error("system clock off while core runs");
endmodule
`default_nettype wire

// ===== verification/rsc_ctrl_tb_top.sv
/* Self-checking bench: register tasks, pin scenarios and reset events.
   Assumes the pin model and a free-running oscillator at 1/8 of clk. */
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl_tb_top;
  logic clk = 0, rst = 1, osc = 0, wr = 0, rd = 0, stop = 0, ext_low = 0;
  logic pin, oe, pout, pwm, chip_reset;
  logic [3:0] addr = 0, ev = 0;
  logic [7:0] wdata = 0, rdata, d;
  int miscompares = 0, checked = 0, cyc = 0, n;
  always #2.5 clk = ~clk;
  always #20 osc = ~osc;
  rsc_ctrl DUT (.clk(clk), .rst(rst), .por_hold(1'b0), .brownout_detect(ev[2]),
    .brownout_stop_keep(1'b0), .watchdog_timeout(ev[0]), .watchdog_reset_select(1'b1),
    .fault_detect(ev[1]), .stop_mode(stop), .osc_tick_pin(osc), .reset_pin_in(pin),
    .recovery_pins({7'h00, ev[3]}), .recovery_enable(8'h01), .option_fault_select_n(1'b1),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .reset_pin_out(pout),
    .reset_pin_oe(oe), .pwm_fault_input_zero(pwm), .chip_reset(chip_reset),
    .debugger_reset_n(), .sys_clk_enable(), .osc_ctrl_reset(), .vector_addr(),
    .vector_fetch(), .watchdog_exception());
  rsc_pin_model PIN (.ext_low(ext_low), .dev_oe(oe), .dev_out(pout), .pin(pin));
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic wait_rst();
    int t;
    t = 0;
    n = 0;
    while (chip_reset !== 1'b1 && t < 40) begin
      @(posedge clk);
      t++;
    end
    while (chip_reset !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("exit", 8'h00, {7'h00, chip_reset});
  endtask
  task automatic pull(input int len);
    ext_low <= 1'b1;
    repeat (len) @(posedge clk);
    ext_low <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic hit(input logic [3:0] e, input logic s, input logic [7:0] exp);
    @(posedge clk);
    stop <= s;
    ev <= e;
    repeat (3) @(posedge clk);
    ev <= 4'h0;
    repeat (20) @(posedge clk);
    if (!s) chk("pin", 8'h00, {7'h00, pin});
    wait_rst();
    // 66 oscillator edges span at least 65 periods; 23 cycles already elapsed
    chk("length", 8'h01, {7'h00, n >= 65 * 8 - 23});
    stop <= 1'b0;
    rd_reg(4'h0);
    chk("cause", exp, d);
  endtask
  task automatic summarize();
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    wait_rst();
    chk("por length", 8'h01, {7'h00, n >= 65 * 8});
    rd_reg(4'h0);
    chk("cause", 8'h80, d);
    wr_reg(4'h0, 8'h14);
    wr_reg(4'h0, 8'h92);
    wr_reg(4'h0, 8'h01);
    rd_reg(4'h0);
    chk("select", 8'h81, d);
    ext_low <= 1'b1;
    repeat (10) @(posedge clk);
    chk("fault in", 8'h01, {7'h00, pwm});
    ext_low <= 1'b0;
    repeat (36) @(posedge clk);
    chk("no reset", 8'h00, {7'h00, chip_reset});
    wr_reg(4'h0, 8'h14);
    wr_reg(4'h0, 8'h55);
    wr_reg(4'h0, 8'h92);
    wr_reg(4'h0, 8'h00);
    rd_reg(4'h0);
    chk("relock", 8'h81, d);
    wr_reg(4'h0, 8'h14);
    wr_reg(4'h0, 8'h92);
    wr_reg(4'h0, 8'h00);
    pull(2);
    repeat (30) @(posedge clk);
    chk("glitch", 8'h00, {7'h00, chip_reset});
    pull(10);
    chk("pin held", 8'h00, {7'h00, pin});
    wait_rst();
    rd_reg(4'h0);
    chk("cause", 8'h10, d);
    hit(4'h1, 1'b0, 8'h20);
    hit(4'h2, 1'b0, 8'h08);
    hit(4'h4, 1'b0, 8'h80);
    hit(4'h8, 1'b1, 8'h40);
    hit(4'h1, 1'b1, 8'h60);
    stop <= 1'b1;
    pull(2);
    wait_rst();
    stop <= 1'b0;
    rd_reg(4'h0);
    chk("stop pin", 8'h10, d);
    wr_reg(4'h1, 8'h01);
    wait_rst();
    rd_reg(4'h1);
    chk("dbg ctl", 8'h00, d);
    rd_reg(4'h0);
    chk("cause", 8'h80, d);
    summarize();
  end
endmodule
bind rsc_ctrl rsc_ctrl_properties u_props (.clk(clk), .rst(rst),
  .brownout_detect(brownout_detect), .watchdog_timeout(watchdog_timeout),
  .watchdog_reset_select(watchdog_reset_select), .stop_mode(stop_mode), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .reset_pin_out(reset_pin_out),
  .reset_pin_oe(reset_pin_oe), .chip_reset(chip_reset), .debugger_reset_n(debugger_reset_n),
  .vector_addr(vector_addr), .vector_fetch(vector_fetch), .osc_ctrl_reset(osc_ctrl_reset),
  .sys_clk_enable(sys_clk_enable));
`default_nettype wire

// ===== verification/rsc_pin_model.sv
/* Board side of the shared reset pin: an external switch and the pull-up.
   Assumes the device only ever sinks the pin through its enable. */
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_model (
  input wire logic ext_low,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic pin
);
  // Pull-up wins when nobody sinks the line, so a released pin reads high
  assign pin = (ext_low || (dev_oe && !dev_out)) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire
